// >>> verilog/rcp_pkg.sv
// Purpose: constants and types for the reset cause and power mode block
// Assumes: APB slave, 32-bit data, 10 MHz system clock
// Notes: one package shared by the single design file
// Functional notes
// (R1) System reset clears non-flag status bits; flags survive until power reset or clear
// (R2) Word, half and byte access; back-to-back status access gets wait states
// (R3) Status bit 0 enables the slow internal oscillator
// (R4) Status bit 1 reads oscillator ready, set while output stable
// (R5) Writing 1 to bit 24 clears all cause flags; 0 does nothing
// (R6) Bit 26 set on external reset pin reset, cleared by clear command
// (R7) Bit 27 set on power-on or power-down reset
// (R8) Bit 28 set on software-requested reset
// (R9) Bit 29 set on independent watchdog reset
// (R10) Bit 30 set on window watchdog reset
// (R11) Bit 31 set on low-power management reset
// (R12) Chip held in reset while supply below power-on/down threshold
// (R13) Supply detector works only while its enable bit is 1
// (R14) Power control bits 2:0 select detector threshold
// (R15) Power status flag shows supply above or below threshold
// (R16) Threshold crossing either way raises detector interrupt when enabled
// (R17) Stop mode stops core-area clocks; any external interrupt wakes
// (R18) Standby removes core-area power; only standby circuitry runs
// (R19) Reserved status bits read zero and ignore writes
// (R20) Sleep stops core clock; interrupt or event wakes per entry
// (R21) Deep sleep, power-down select 0 and wait enter stop mode
// (R22) Deep sleep, select 1, wake flag 0 and wait enter standby
// (R23) Wake pin, RTC, external reset or watchdog end standby via reset
package rcp_pkg;
    localparam logic [7:0] RCP_OFF_PWR_CTRL = 8'h00;
    localparam logic [7:0] RCP_OFF_PWR_STAT = 8'h04;
    localparam logic [7:0] RCP_OFF_RST_STAT = 8'h24;
    localparam logic [7:0] RCP_OFF_MODE_CTRL = 8'h08;
    localparam logic [31:0] RCP_RST_STAT_RESET = 32'h0C000000;
    localparam int RCP_BIT_OSC_EN = 0;
    localparam int RCP_BIT_OSC_RDY = 1;
    localparam int RCP_BIT_CLR = 24;
    localparam int RCP_BIT_FLAG_LO = 26;
    localparam int RCP_NUM_FLAGS = 6;
    // Power control fields
    localparam int RCP_BIT_PLS_LO = 0;
    localparam int RCP_BIT_REG_LP = 3;
    localparam int RCP_BIT_PDSEL = 4;
    localparam int RCP_BIT_DET_EN = 5;
    localparam int RCP_BIT_DET_IE = 6;
    // Power status fields
    localparam int RCP_BIT_WAKE_FLAG = 0;
    localparam int RCP_BIT_DET_OUT = 2;
    // Mode control fields
    localparam int RCP_BIT_DEEP = 0;
    localparam int RCP_WAIT_STATES = 1;
    localparam logic [6:0] RCP_PWR_CTRL_MASK = 7'h7F;

    typedef struct packed {
        logic pin;
        logic por;
        logic sw;
        logic iwdg;
        logic wwdg;
        logic lpwr;
    } rcp_cause_t;

    typedef struct packed {
        logic wait_for_interrupt;
        logic wait_for_event;
        logic irq;
        logic ext_irq;
        logic event_in;
        logic wake_pin;
        logic rtc_wake;
    } rcp_cpu_t;
endpackage

// >>> verilog/rcp_reset_power.sv
// Purpose: reset cause record, slow oscillator control, supply detector,
//          low-power mode sequencing
// Assumes: APB slave on clk_sys_i; flags kept on power reset only
// Notes: reset causes arrive as one-cycle pulses from the reset controller
//
// The APB interface to the registers was decided locally.
module rcp_reset_power #(
    parameter int OSC_SETTLE = 8
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic power_reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire rcp_pkg::rcp_cause_t cause_i,
    input wire logic supply_low_i,
    input wire logic supply_below_thr_i,
    input wire rcp_pkg::rcp_cpu_t cpu_i,
    output logic osc_enable_o,
    output logic [2:0] supply_threshold_select_o,
    output logic detector_enable_o,
    output logic detector_irq_o,
    output logic hold_reset_o,
    output logic core_clk_stop_o,
    output logic core_area_clk_stop_o,
    output logic regulator_low_power_o,
    output logic core_power_off_o
);
    typedef enum logic [3:0] {
        RCP_RUN = 4'h1,
        RCP_SLEEP = 4'h2,
        RCP_STOP = 4'h4,
        RCP_STANDBY = 4'h8
    } rcp_mode_t;

    rcp_mode_t mode_reg;
    rcp_mode_t mode_next;
    logic [rcp_pkg::RCP_NUM_FLAGS-1:0] flag_reg;
    logic osc_en_reg;
    logic [7:0] osc_cnt_reg;
    logic osc_rdy_reg;
    logic [6:0] pwr_ctrl_reg;
    logic deep_reg;
    logic wake_flag_reg;
    logic sleep_by_wfe_reg;
    logic [2:0] sup_sync_reg;
    logic det_out_reg;
    logic irq_reg;
    logic wait_reg;
    logic last_stat_reg;
    logic clr_hit;
    logic [rcp_pkg::RCP_NUM_FLAGS-1:0] cause_vec;
    logic access;
    logic wr_ok;
    logic stat_sel;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    assign access = psel_i && penable_i;
    assign stat_sel = hit(paddr_i, rcp_pkg::RCP_OFF_RST_STAT);
    // (R2) Back-to-back wait state
    assign pready_o = !(stat_sel && last_stat_reg && !wait_reg);
    assign pslverr_o = 1'b0;
    assign wr_ok = access && pready_o && pwrite_i;
    // (R5) Clear on write of one
    assign clr_hit = wr_ok && stat_sel && pstrb_i[rcp_pkg::RCP_BIT_CLR/8]
                     && pwdata_i[rcp_pkg::RCP_BIT_CLR];
    assign cause_vec = {cause_i.lpwr, cause_i.wwdg, cause_i.iwdg,
                        cause_i.sw, cause_i.por, cause_i.pin};

    // (R2) Stall tracker
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_reg <= 1'b0;
            last_stat_reg <= 1'b0;
        end else begin
            wait_reg <= access && !pready_o;
            if (access && pready_o) begin
                last_stat_reg <= stat_sel;
            end else if (!psel_i) begin
                last_stat_reg <= 1'b0;
            end
        end
    end

    // Flags live on the power reset only; set wins over the clear
    genvar g;
    generate
        for (g = 0; g < rcp_pkg::RCP_NUM_FLAGS; g++) begin : g_flag
            // (R1) (R6) (R7) (R8) (R9) (R10) (R11) Sticky cause flags
            always_ff @(posedge clk_sys_i or negedge power_reset_n_i) begin
                if (!power_reset_n_i) begin
                    flag_reg[g] <= rcp_pkg::RCP_RST_STAT_RESET[
                        rcp_pkg::RCP_BIT_FLAG_LO + g];
                end else if (cause_vec[g]) begin
                    flag_reg[g] <= 1'b1;
                end else if (clr_hit) begin
                    flag_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // (R3) Oscillator enable
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            osc_en_reg <= 1'b0;
        end else if (wr_ok && stat_sel && pstrb_i[0]) begin
            osc_en_reg <= pwdata_i[rcp_pkg::RCP_BIT_OSC_EN];
        end
    end

    // (R4) Ready after settle count, drops when disabled
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            osc_cnt_reg <= 8'h00;
            osc_rdy_reg <= 1'b0;
        end else if (!osc_en_reg) begin
            osc_cnt_reg <= 8'h00;
            osc_rdy_reg <= 1'b0;
        end else if (osc_cnt_reg == 8'(OSC_SETTLE)) begin
            osc_rdy_reg <= 1'b1;
        end else begin
            osc_cnt_reg <= osc_cnt_reg + 8'h01;
        end
    end

    // (R13) (R14) Power and mode control
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwr_ctrl_reg <= 7'h00;
            deep_reg <= 1'b0;
        end else if (wr_ok && pstrb_i[0]) begin
            if (hit(paddr_i, rcp_pkg::RCP_OFF_PWR_CTRL)) begin
                pwr_ctrl_reg <= pwdata_i[6:0] & rcp_pkg::RCP_PWR_CTRL_MASK;
            end
            if (hit(paddr_i, rcp_pkg::RCP_OFF_MODE_CTRL)) begin
                deep_reg <= pwdata_i[rcp_pkg::RCP_BIT_DEEP];
            end
        end
    end

    // Supply comparator is asynchronous: three stages, last two agree
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sup_sync_reg <= 3'h0;
        end else begin
            sup_sync_reg <= {sup_sync_reg[1:0], supply_below_thr_i};
        end
    end

    // (R15) (R16) Detector output and crossing interrupt
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            det_out_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= 1'b0;
            // (R13) Gated by enable
            if (!pwr_ctrl_reg[rcp_pkg::RCP_BIT_DET_EN]) begin
                det_out_reg <= 1'b0;
            end else if (sup_sync_reg[2] == sup_sync_reg[1] &&
                         sup_sync_reg[2] != det_out_reg) begin
                det_out_reg <= sup_sync_reg[2];
                irq_reg <= pwr_ctrl_reg[rcp_pkg::RCP_BIT_DET_IE];
            end
        end
    end

    // (R20) (R21) (R22) (R23) (R17) (R18) Mode sequencer
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            RCP_RUN: begin
                if (cpu_i.wait_for_interrupt || cpu_i.wait_for_event) begin
                    if (!deep_reg) begin
                        mode_next = RCP_SLEEP;
                    end else if (!pwr_ctrl_reg[rcp_pkg::RCP_BIT_PDSEL]) begin
                        mode_next = RCP_STOP;
                    end else if (!wake_flag_reg) begin
                        mode_next = RCP_STANDBY;
                    end
                end
            end
            RCP_SLEEP: begin
                if (sleep_by_wfe_reg ? cpu_i.event_in : cpu_i.irq) begin
                    mode_next = RCP_RUN;
                end
            end
            RCP_STOP: begin
                if (cpu_i.ext_irq || (sleep_by_wfe_reg && cpu_i.event_in)) begin
                    mode_next = RCP_RUN;
                end
            end
            RCP_STANDBY: begin
                // Exit is a chip reset, which returns the mode to run
                mode_next = RCP_STANDBY;
            end
            default: mode_next = RCP_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_reg <= RCP_RUN;
            sleep_by_wfe_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            if (mode_reg == RCP_RUN) begin
                sleep_by_wfe_reg <= cpu_i.wait_for_event && !cpu_i.wait_for_interrupt;
            end
        end
    end

    // (R22) (R23) Wake flag set on standby wake pin or alarm
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_flag_reg <= 1'b0;
        end else if (cpu_i.wake_pin || cpu_i.rtc_wake) begin
            wake_flag_reg <= 1'b1;
        end else if (wr_ok && hit(paddr_i, rcp_pkg::RCP_OFF_PWR_STAT) &&
                     pstrb_i[0] && pwdata_i[rcp_pkg::RCP_BIT_WAKE_FLAG]) begin
            wake_flag_reg <= 1'b0;
        end
    end

    // Read data registered at the access edge
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o <= 32'h00000000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= 32'h00000000;
            if (stat_sel) begin
                // (R19) Reserved bits zero
                prdata_o[rcp_pkg::RCP_BIT_OSC_EN] <= osc_en_reg;
                prdata_o[rcp_pkg::RCP_BIT_OSC_RDY] <= osc_rdy_reg;
                prdata_o[rcp_pkg::RCP_BIT_FLAG_LO +: rcp_pkg::RCP_NUM_FLAGS]
                    <= flag_reg;
            end else if (hit(paddr_i, rcp_pkg::RCP_OFF_PWR_CTRL)) begin
                prdata_o[6:0] <= pwr_ctrl_reg;
            end else if (hit(paddr_i, rcp_pkg::RCP_OFF_PWR_STAT)) begin
                prdata_o[rcp_pkg::RCP_BIT_WAKE_FLAG] <= wake_flag_reg;
                prdata_o[rcp_pkg::RCP_BIT_DET_OUT] <= det_out_reg;
            end else if (hit(paddr_i, rcp_pkg::RCP_OFF_MODE_CTRL)) begin
                prdata_o[rcp_pkg::RCP_BIT_DEEP] <= deep_reg;
            end
        end
    end

    assign osc_enable_o = osc_en_reg;
    assign supply_threshold_select_o = pwr_ctrl_reg[2:0];
    assign detector_enable_o = pwr_ctrl_reg[rcp_pkg::RCP_BIT_DET_EN];
    assign detector_irq_o = irq_reg;
    // (R12) Hold reset while supply low
    assign hold_reset_o = supply_low_i;
    // (R20) Core clock stops in every low-power mode
    assign core_clk_stop_o = mode_reg != RCP_RUN;
    // (R17) Core-area clocks stop
    assign core_area_clk_stop_o = mode_reg == RCP_STOP ||
                                  mode_reg == RCP_STANDBY;
    // (R21) Regulator choice in stop
    assign regulator_low_power_o = mode_reg == RCP_STOP &&
                                   pwr_ctrl_reg[rcp_pkg::RCP_BIT_REG_LP];
    // (R18) Core area unpowered
    assign core_power_off_o = mode_reg == RCP_STANDBY;
endmodule

// >>> sim/rcp_asserts.sv
// Purpose: concurrent checks on the reset cause and power mode block
// Assumes: APB master holds each request until pready, one clock domain
// Notes: sees top-level ports only; bound to every block instance
module rcp_asserts (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic supply_low_i,
    input wire logic osc_enable_o,
    input wire logic [2:0] supply_threshold_select_o,
    input wire logic detector_enable_o,
    input wire logic detector_irq_o,
    input wire logic hold_reset_o,
    input wire logic core_clk_stop_o,
    input wire logic core_area_clk_stop_o,
    input wire logic core_power_off_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    wire logic done_w = psel_i && penable_i && pready_o;
    wire logic st_w = paddr_i == rcp_pkg::RCP_OFF_RST_STAT;
    wire logic pc_w = paddr_i == rcp_pkg::RCP_OFF_PWR_CTRL;
    sequence s_st_done;
        done_w && st_w;
    endsequence
    sequence s_st_setup;
        psel_i && !penable_i && st_w;
    endsequence
    AST_STAT_WAIT: assert property (
        s_st_done ##1 s_st_setup |=> !pready_o ##1 pready_o)
        else $error("no wait state on back-to-back status access");
    AST_OSC_EN: assert property (
        done_w && pwrite_i && st_w && pstrb_i[0]
        |=> osc_enable_o == $past(pwdata_i[0]))
        else $error("oscillator enable not written");
    // Ready lags the enable and a wait state delays the read: three cycles
    AST_OSC_RDY: assert property (
        done_w && !pwrite_i && st_w && !$past(osc_enable_o)
        && !$past(osc_enable_o, 2) && !$past(osc_enable_o, 3)
        |-> !prdata_o[1])
        else $error("oscillator ready while disabled");
    AST_RSV: assert property (
        done_w && !pwrite_i && st_w |-> prdata_o[23:2] == 22'h0
        && !prdata_o[25])
        else $error("reserved status bits not zero");
    AST_THR: assert property (
        done_w && pwrite_i && pc_w && pstrb_i[0]
        |=> supply_threshold_select_o == $past(pwdata_i[2:0]))
        else $error("threshold select not written");
    AST_DET_EN: assert property (
        done_w && pwrite_i && pc_w && pstrb_i[0]
        |=> detector_enable_o == $past(pwdata_i[5]))
        else $error("detector enable not written");
    AST_DET_OFF: assert property (
        !detector_enable_o [*4] |-> !detector_irq_o)
        else $error("detector interrupt while disabled");
    AST_HOLD: assert property (
        hold_reset_o == supply_low_i)
        else $error("reset hold does not follow supply");
    AST_STOP: assert property (
        core_area_clk_stop_o |-> core_clk_stop_o)
        else $error("core clock runs in stop mode");
    AST_STANDBY: assert property (
        core_power_off_o |=> core_power_off_o)
        else $error("standby left without reset");
endmodule

bind rcp_reset_power rcp_asserts rcp_asserts_i (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .supply_low_i(supply_low_i),
    .osc_enable_o(osc_enable_o),
    .supply_threshold_select_o(supply_threshold_select_o),
    .detector_enable_o(detector_enable_o),
    .detector_irq_o(detector_irq_o), .hold_reset_o(hold_reset_o),
    .core_clk_stop_o(core_clk_stop_o),
    .core_area_clk_stop_o(core_area_clk_stop_o),
    .core_power_off_o(core_power_off_o)
);

// >>> sim/tb_rcp_reset_power.sv
// Purpose: directed APB tests of the reset cause and power mode block
// Assumes: 10 MHz clock, oscillator settle shortened to 2 cycles
// Notes: bus answer, register outputs and the power-off check after reset taken at the rising edge, irq, hold and other mode outputs on the falling
module tb_rcp_reset_power;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A_PC = rcp_pkg::RCP_OFF_PWR_CTRL;
    localparam logic [7:0] A_PS = rcp_pkg::RCP_OFF_PWR_STAT;
    localparam logic [7:0] A_ST = rcp_pkg::RCP_OFF_RST_STAT;
    localparam logic [7:0] A_MC = rcp_pkg::RCP_OFF_MODE_CTRL;
    logic clk_sys_i = 1'h0, reset_n_i = 1'h0, power_reset_n_i = 1'h0;
    logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd, exp;
    logic [3:0] pstrb_i = 4'h0;
    logic pready_o, pslverr_o, supply_low_i = 1'h0, supply_below_thr_i = 1'h0;
    rcp_pkg::rcp_cause_t cause_i = '0;
    rcp_pkg::rcp_cpu_t cpu_i = '0;
    logic osc_enable_o, detector_enable_o, detector_irq_o, hold_reset_o;
    logic [2:0] supply_threshold_select_o;
    logic core_clk_stop_o, core_area_clk_stop_o, regulator_low_power_o;
    logic core_power_off_o;
    int n_errors = 0, n_tests = 0, i;
    rcp_reset_power #(.OSC_SETTLE(2)) rcp_reset_power_i (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .power_reset_n_i(power_reset_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .cause_i(cause_i),
        .supply_low_i(supply_low_i), .supply_below_thr_i(supply_below_thr_i),
        .cpu_i(cpu_i), .osc_enable_o(osc_enable_o),
        .supply_threshold_select_o(supply_threshold_select_o),
        .detector_enable_o(detector_enable_o),
        .detector_irq_o(detector_irq_o), .hold_reset_o(hold_reset_o),
        .core_clk_stop_o(core_clk_stop_o),
        .core_area_clk_stop_o(core_area_clk_stop_o),
        .regulator_low_power_o(regulator_low_power_o),
        .core_power_off_o(core_power_off_o));
    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    task automatic end_sim();
        $display("compares %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] e,
                         input string msg);
        n_tests++;
        if (seen !== e) begin
            n_errors++;
            $display("wrong value at %0t: %s %h not %h", $time, msg, seen, e);
        end
    endtask
    // Leaves the bus selected so the next call may follow at once
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        logic rdy;
        rdy = 1'h0;
        psel_i <= 1'h1;
        penable_i <= 1'h0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clk_sys_i);
        penable_i <= 1'h1;
        for (int k = 0; k < 20 && !rdy; k++) begin
            @(posedge clk_sys_i);
            rdy = (pready_o === 1'h1);
            rd = prdata_o;
        end
        if (!rdy) begin
            n_errors++;
            end_sim();
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string msg);
        apb(1'h0, a, 32'h0, 4'h0);
        check(rd, e, msg);
    endtask
    task automatic idle(input int n);
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic sys_reset();
        reset_n_i <= 1'h0;
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'h1;
        @(posedge clk_sys_i);
    endtask
    task automatic wait_irq(input logic e, input string msg);
        logic seen;
        seen = 1'h0;
        repeat (20) begin
            @(negedge clk_sys_i);
            seen = seen | (detector_irq_o === 1'h1);
        end
        @(posedge clk_sys_i);
        check(seen, e, msg);
    endtask
    task automatic mode(input logic [6:0] c, input logic [3:0] m,
                        input logic [3:0] e, input string msg);
        cpu_i <= c;
        @(posedge clk_sys_i);
        cpu_i <= '0;
        repeat (2) @(negedge clk_sys_i);
        check({core_clk_stop_o, core_area_clk_stop_o, regulator_low_power_o,
               core_power_off_o} & m, e, msg);
        @(posedge clk_sys_i);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_i);
        power_reset_n_i <= 1'h1;
        reset_n_i <= 1'h1;
        @(posedge clk_sys_i);
        rdchk(A_ST, 32'h0C000000, "status reset");
        apb(1'h1, A_ST, 32'h02FFFFFD, 4'hF);
        apb(1'h0, A_ST, 32'h0, 4'h0);
        check(rd & 32'hFFFFFFFD, 32'h0C000001, "reserved");
        idle(6);
        rdchk(A_ST, 32'h0C000003, "osc ready");
        check(osc_enable_o, 1'h1, "osc enable");
        apb(1'h1, A_ST, 32'h0, 4'h1);
        idle(6);
        rdchk(A_ST, 32'h0C000000, "osc off");
        apb(1'h1, A_ST, 32'h1, 4'hE);
        rdchk(A_ST, 32'h0C000000, "lane 0 not strobed");
        apb(1'h1, A_ST, 32'h01000000, 4'h8);
        rdchk(A_ST, 32'h0, "flags cleared");
        rdchk(8'h10, 32'h0, "unmapped reads zero");
        check(pslverr_o, 1'h0, "no error response");
        $display("test status bits done");
        exp = 32'h0;
        for (i = 0; i < 6; i++) begin
            cause_i <= rcp_pkg::rcp_cause_t'(6'h20 >> i);
            idle(1);
            cause_i <= '0;
            exp[26 + i] = 1'h1;
            rdchk(A_ST, exp, "cause flag");
        end
        apb(1'h1, A_ST, 32'h1, 4'h1);
        idle(4);
        sys_reset();
        rdchk(A_ST, 32'hFC000000, "flags kept");
        check(osc_enable_o, 1'h0, "enable reset");
        apb(1'h1, A_ST, 32'h01000000, 4'h8);
        rdchk(A_ST, 32'h0, "all cleared");
        $display("test cause flags done");
        for (i = 0; i < 8; i++) begin
            apb(1'h1, A_PC, 32'h20 | i, 4'h1);
            rdchk(A_PC, 32'h20 | i, "power control");
            check(supply_threshold_select_o, i[2:0], "threshold");
            check(detector_enable_o, 1'h1, "detector on");
        end
        apb(1'h1, A_PC, 32'h60, 4'h1);
        idle(1);
        supply_below_thr_i <= 1'h1;
        wait_irq(1'h1, "irq falling");
        rdchk(A_PS, 32'h4, "below");
        idle(1);
        supply_below_thr_i <= 1'h0;
        wait_irq(1'h1, "irq rising");
        rdchk(A_PS, 32'h0, "above");
        apb(1'h1, A_PC, 32'h20, 4'h1);
        idle(1);
        supply_below_thr_i <= 1'h1;
        wait_irq(1'h0, "irq masked");
        rdchk(A_PS, 32'h4, "below masked");
        idle(1);
        supply_below_thr_i <= 1'h0;
        apb(1'h1, A_PC, 32'h0, 4'h1);
        idle(30);
        supply_below_thr_i <= 1'h1;
        wait_irq(1'h0, "irq while off");
        rdchk(A_PS, 32'h0, "detector off");
        idle(1);
        supply_low_i <= 1'h1;
        @(negedge clk_sys_i);
        check(hold_reset_o, 1'h1, "hold reset");
        @(posedge clk_sys_i);
        supply_low_i <= 1'h0;
        $display("test supply monitor done");
        mode(7'h40, 4'hF, 4'h8, "sleep wfi");
        mode(7'h10, 4'hF, 4'h0, "irq wake");
        mode(7'h20, 4'hF, 4'h8, "sleep wfe");
        mode(7'h10, 4'hF, 4'h8, "irq ignored");
        mode(7'h04, 4'hF, 4'h0, "event wake");
        apb(1'h1, A_PC, 32'h08, 4'h1);
        apb(1'h1, A_MC, 32'h1, 4'h1);
        rdchk(A_MC, 32'h1, "deep sleep select");
        idle(1);
        mode(7'h40, 4'hF, 4'hE, "stop");
        mode(7'h08, 4'hF, 4'h0, "ext irq wake");
        apb(1'h1, A_PC, 32'h0, 4'h1);
        idle(1);
        mode(7'h40, 4'hE, 4'hC, "stop normal regulator");
        mode(7'h08, 4'hF, 4'h0, "wake again");
        apb(1'h1, A_PC, 32'h10, 4'h1);
        idle(1);
        mode(7'h01, 4'h1, 4'h0, "wake flag set");
        mode(7'h40, 4'h1, 4'h0, "wake flag blocks standby");
        rdchk(A_PS, 32'h1, "wake flag");
        apb(1'h1, A_PS, 32'h1, 4'h1);
        idle(1);
        mode(7'h40, 4'h1, 4'h1, "standby");
        mode(7'h02, 4'h1, 4'h1, "needs reset");
        sys_reset();
        check(core_power_off_o, 1'h0, "reset ends standby");
        $display("test low power modes done");
        end_sim();
    end
endmodule
